/* pwmg_defines.svh */
`ifndef PWMG_DEFINES_SVH
`define PWMG_DEFINES_SVH
// register byte offsets
`define PWMG_CFG     8'h00
`define PWMG_ENA     8'h04
`define PWMG_LOAD    8'h08
`define PWMG_CMPA    8'h0c
`define PWMG_CMPB    8'h10
`define PWMG_DBCTL   8'h14
`define PWMG_DBRISE  8'h18
`define PWMG_DBFALL  8'h1c
`define PWMG_INTEN   8'h20
`define PWMG_RIS     8'h24
`define PWMG_MIS     8'h28
`define PWMG_SYNC    8'h2c
`define PWMG_ISC     8'h30
`define PWMG_COUNT   8'h34
// field positions
`define PWMG_CFG_UPDOWN  0
`define PWMG_CFG_SYNC    1
`define PWMG_CFG_RUNHALT 2
`define PWMG_EN_BIT      0
`define PWMG_TRG_LSB     8
`define PWMG_FAULT_BIT   0
`define PWMG_EV_ZERO     0
`define PWMG_EV_LOAD     1
`define PWMG_EV_AU       2
`define PWMG_EV_AD       3
`define PWMG_EV_BU       4
`define PWMG_EV_BD       5
// reset values and responses
`define PWMG_RST16  16'h0000
`define PWMG_RST6   6'h00
`define PWMG_OKAY   2'b00
`define PWMG_SLVERR 2'b10
`endif

/* pwmg_pkg.sv */
package pwmg_pkg;
	typedef enum logic [1:0] {
		DB_LOW  = 2'b00,
		DB_RISE = 2'b01,
		DB_HIGH = 2'b10,
		DB_FALL = 2'b11
	} pwmg_db_phase_t;

	typedef struct packed {
		logic        wr;
		logic [7:0]  waddr;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic [7:0]  raddr;
	} pwmg_req_t;

	typedef struct packed {
		logic [31:0] rdata;
		logic        rerr;
		logic        werr;
	} pwmg_rsp_t;

	typedef struct packed {
		logic run_in_halt_select;
		logic sync_mode;
		logic updown;
	} pwmg_cfg_t;

	typedef struct packed {
		logic        aw_full;
		logic [7:0]  awaddr;
		logic        w_full;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} pwmg_axil_st_t;

	typedef struct packed {
		pwmg_db_phase_t phase;
		logic [15:0]    cnt;
		logic           a;
		logic           b;
	} pwmg_db_st_t;

	typedef struct packed {
		pwmg_cfg_t   cfg;
		logic        en;
		logic [15:0] load;
		logic [15:0] cmpa;
		logic [15:0] cmpb;
		logic [15:0] pend_load;
		logic [15:0] pend_cmpa;
		logic [15:0] pend_cmpb;
		logic        pend;
		logic        synced;
		logic [15:0] cnt;
		logic        dir_up;
		logic        raw_a;
		logic        raw_b;
		logic        db_en;
		logic [15:0] db_rise;
		logic [15:0] db_fall;
		logic [5:0]  int_en;
		logic [5:0]  trg_en;
		logic [5:0]  ris;
		logic        fault;
		logic        trig;
		logic        int_req;
	} pwmg_gen_st_t;
endpackage : pwmg_pkg

/* pwmg_axil.sv */
`timescale 1ns/1ps
`include "pwmg_defines.svh"
module pwmg_axil (
	// clock and reset
	input  wire logic              aclk,
	input  wire logic              aresetn,
	// axi4-lite slave
	input  wire logic [7:0]        awaddr,
	input  wire logic              awvalid,
	output logic                   awready,
	input  wire logic [31:0]       wdata,
	input  wire logic [3:0]        wstrb,
	input  wire logic              wvalid,
	output logic                   wready,
	output logic [1:0]             bresp,
	output logic                   bvalid,
	input  wire logic              bready,
	input  wire logic [7:0]        araddr,
	input  wire logic              arvalid,
	output logic                   arready,
	output logic [31:0]            rdata,
	output logic [1:0]             rresp,
	output logic                   rvalid,
	input  wire logic              rready,
	// register access
	output pwmg_pkg::pwmg_req_t    req,
	input  wire pwmg_pkg::pwmg_rsp_t rsp
);
	pwmg_pkg::pwmg_axil_st_t st;
	pwmg_pkg::pwmg_axil_st_t next_st;

	assign awready = !st.aw_full;
	assign wready  = !st.w_full;
	assign arready = !st.rvalid;
	assign bvalid  = st.bvalid;
	assign bresp   = st.bresp;
	assign rvalid  = st.rvalid;
	assign rdata   = st.rdata;
	assign rresp   = st.rresp;

	always_comb begin
		req.wr    = st.aw_full && st.w_full && !st.bvalid;
		req.waddr = st.awaddr;
		req.wdata = st.wdata;
		req.wstrb = st.wstrb;
		req.raddr = araddr;
		next_st = st;
		if (awvalid && !st.aw_full) begin
			next_st.aw_full = 1'b1;
			next_st.awaddr  = awaddr;
		end
		if (wvalid && !st.w_full) begin
			next_st.w_full = 1'b1;
			next_st.wdata  = wdata;
			next_st.wstrb  = wstrb;
		end
		if (req.wr) begin
			next_st.aw_full = 1'b0;
			next_st.w_full  = 1'b0;
			next_st.bvalid  = 1'b1;
			next_st.bresp   = rsp.werr ? `PWMG_SLVERR : `PWMG_OKAY;
		end else if (st.bvalid && bready) begin
			next_st.bvalid = 1'b0;
		end
		if (arvalid && !st.rvalid) begin
			next_st.rvalid = 1'b1;
			next_st.rdata  = rsp.rdata;
			next_st.rresp  = rsp.rerr ? `PWMG_SLVERR : `PWMG_OKAY;
		end else if (st.rvalid && rready) begin
			next_st.rvalid = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end
endmodule : pwmg_axil

/* pwmg_dead_band.sv */
`timescale 1ns/1ps
module pwmg_dead_band (
	// clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// control
	input  wire logic        db_en,
	input  wire logic [15:0] rise_dly,
	input  wire logic [15:0] fall_dly,
	// comparator levels in, pin levels out
	input  wire logic        raw_a,
	input  wire logic        raw_b,
	output logic             out_a,
	output logic             out_b
);
	pwmg_pkg::pwmg_db_st_t st;
	pwmg_pkg::pwmg_db_st_t next_st;

	assign out_a = st.a;
	assign out_b = st.b;

	always_comb begin
		next_st = st;
		if (!db_en) begin
			next_st.phase = raw_a ? pwmg_pkg::DB_HIGH : pwmg_pkg::DB_LOW;
			next_st.a     = raw_a;
			next_st.b     = raw_b;
		end else begin
			// second output follows the inverse of the first, not its comparator
			case (st.phase)
				pwmg_pkg::DB_LOW: begin
					next_st.a = 1'b0;
					next_st.b = !raw_a; // RL2
					if (raw_a) begin
						next_st.phase = pwmg_pkg::DB_RISE;
						next_st.cnt   = rise_dly; // RL1
					end
				end
				pwmg_pkg::DB_RISE: begin
					next_st.b = 1'b0;
					if (!raw_a) begin
						next_st.phase = pwmg_pkg::DB_FALL;
						next_st.cnt   = fall_dly;
					end else if (st.cnt <= 16'h0001) begin
						next_st.a     = 1'b1; // RL1
						next_st.phase = pwmg_pkg::DB_HIGH;
					end else begin
						next_st.cnt = st.cnt - 16'h0001;
					end
				end
				pwmg_pkg::DB_HIGH: begin
					next_st.a = raw_a;
					next_st.b = 1'b0;
					if (!raw_a) begin
						next_st.phase = pwmg_pkg::DB_FALL;
						next_st.cnt   = fall_dly; // RL1
					end
				end
				pwmg_pkg::DB_FALL: begin
					next_st.a = 1'b0;
					if (raw_a) begin
						next_st.b     = 1'b0;
						next_st.phase = pwmg_pkg::DB_RISE;
						next_st.cnt   = rise_dly;
					end else if (st.cnt <= 16'h0001) begin
						next_st.b     = 1'b1; // RL2
						next_st.phase = pwmg_pkg::DB_LOW;
					end else begin
						next_st.cnt = st.cnt - 16'h0001;
					end
				end
				default: next_st.phase = pwmg_pkg::DB_LOW;
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	db_no_overlap_a: assert property (@(posedge aclk) disable iff (!aresetn) // RL2
		db_en && $past(db_en) |-> !(out_a && out_b))
		else $error("dead band outputs both high");
	db_rise_end_a: assert property (@(posedge aclk) disable iff (!aresetn) // RL1
		db_en && st.phase == pwmg_pkg::DB_RISE && raw_a && st.cnt == 16'h0001 |=> out_a)
		else $error("rising delay did not end on its count");
	db_rise_hold_a: assert property (@(posedge aclk) disable iff (!aresetn) // RL1
		db_en && st.phase == pwmg_pkg::DB_LOW && raw_a && rise_dly == 16'h0002
		##1 db_en && raw_a |-> !out_a ##1 !out_a)
		else $error("rising edge passed before its delay");
endmodule : pwmg_dead_band

/* pwmg_gen.sv */
`timescale 1ns/1ps
`include "pwmg_defines.svh"
// Behaviour
// RL1 - with dead band on, delay first output edges by rise and fall counts; code delays only its rise, fall count delays the second output's rise
// RL2 - dead band on: second output is complement of first, not its comparator
// RL3 - writing the configuration register leaves the counter disabled
// RL4 - down mode counts load value down to zero then reloads
// RL5 - up/down mode counts zero to load and back down, repeating
// RL6 - synchronised mode holds new period and widths until a sync event
// RL7 - one sync event applies pending values to all selected generators
// RL8 - unsynchronised mode applies new values at the next counter zero
// RL9 - new values move into the active set only while counter is zero
// RL10 - pause on halt: count on to zero, then hold until resume
// RL11 - run on halt: counter ignores the debug halt
// RL12 - disabled generator counter does not advance
// RL13 - enabled generator counter advances each clock
// RL14 - event status bits clear on writing one, zero leaves them
// RL15 - six events: zero, load, A up, A down, B up, B down
// RL16 - raw and masked views of event status are both readable
// RL17 - writing the fault bit of module status clears the fault flag
// RL18 - software should clear event sources early in its handler
// RL19 - counter is sixteen bits, down or up/down
// RL20 - period is clock ticks between counter zero events
// RL21 - enable register gates events onto interrupt and trigger
// RL22 - comparator A shapes first output, comparator B the second
module pwmg_gen (
	// clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// axi4-lite slave
	input  wire logic [7:0]  awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	input  wire logic [7:0]  araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	// system
	input  wire logic        debug_halt,
	input  wire logic        fault_in,
	// outputs
	output logic             first_output,
	output logic             second_output,
	output logic             trig_pulse,
	output logic             int_req
);
	pwmg_pkg::pwmg_gen_st_t st;
	pwmg_pkg::pwmg_gen_st_t next_st;
	pwmg_pkg::pwmg_req_t    req;
	pwmg_pkg::pwmg_rsp_t    rsp;
	logic                   run;
	logic                   apply;
	logic                   sync_evt;
	logic [5:0]             evt;
	logic [5:0]             clr;
	logic [5:0]             mis;

	function automatic logic mapped(input logic [7:0] a);
		mapped = (a[1:0] == 2'b00) && (a <= `PWMG_COUNT);
	endfunction : mapped

	function automatic logic [15:0] merge16(input logic [15:0] old,
		input logic [31:0] d, input logic [3:0] s);
		merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
	endfunction : merge16

	function automatic logic wr_at(input pwmg_pkg::pwmg_req_t r, input logic [7:0] a);
		wr_at = r.wr && (r.waddr == a);
	endfunction : wr_at

	pwmg_axil u_axil (
		.aclk    (aclk),
		.aresetn (aresetn),
		.awaddr  (awaddr),
		.awvalid (awvalid),
		.awready (awready),
		.wdata   (wdata),
		.wstrb   (wstrb),
		.wvalid  (wvalid),
		.wready  (wready),
		.bresp   (bresp),
		.bvalid  (bvalid),
		.bready  (bready),
		.araddr  (araddr),
		.arvalid (arvalid),
		.arready (arready),
		.rdata   (rdata),
		.rresp   (rresp),
		.rvalid  (rvalid),
		.rready  (rready),
		.req     (req),
		.rsp     (rsp)
	);

	pwmg_dead_band u_db (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.db_en    (st.db_en),
		.rise_dly (st.db_rise),
		.fall_dly (st.db_fall),
		.raw_a    (st.raw_a),
		.raw_b    (st.raw_b),
		.out_a    (first_output),
		.out_b    (second_output)
	);

	assign trig_pulse = st.trig;
	assign int_req    = st.int_req;
	assign mis        = st.ris & st.int_en; // RL16

	// pause on halt only once the counter sits at zero, so no pulse is cut short
	assign run = st.en && !(debug_halt && !st.cfg.run_in_halt_select // RL10 RL11 RL12 RL13
		&& st.cnt == `PWMG_RST16);
	assign sync_evt = wr_at(req, `PWMG_SYNC) && req.wstrb[0] && req.wdata[0];
	// transfer only at zero; sync mode also waits for the sync event
	assign apply = st.pend && st.cnt == `PWMG_RST16 // RL9
		&& (!st.cfg.sync_mode || st.synced || sync_evt); // RL6 RL7 RL8

	always_comb begin
		evt = `PWMG_RST6;
		if (run) begin
			evt[`PWMG_EV_ZERO] = st.cnt == `PWMG_RST16; // RL15 RL20
			evt[`PWMG_EV_LOAD] = st.cnt == st.load;
			evt[`PWMG_EV_AU]   = st.cnt == st.cmpa && st.cfg.updown && st.dir_up;
			evt[`PWMG_EV_AD]   = st.cnt == st.cmpa && !(st.cfg.updown && st.dir_up);
			evt[`PWMG_EV_BU]   = st.cnt == st.cmpb && st.cfg.updown && st.dir_up;
			evt[`PWMG_EV_BD]   = st.cnt == st.cmpb && !(st.cfg.updown && st.dir_up);
		end
	end

	always_comb begin
		clr = `PWMG_RST6;
		if ((wr_at(req, `PWMG_RIS) || wr_at(req, `PWMG_MIS)) && req.wstrb[0]) begin
			clr = req.wdata[5:0]; // RL14
		end
	end

	always_comb begin
		rsp.werr  = !mapped(req.waddr);
		rsp.rerr  = !mapped(req.raddr);
		rsp.rdata = 32'h0000_0000;
		if (req.raddr == `PWMG_CFG) begin
			rsp.rdata[2:0] = st.cfg;
		end else if (req.raddr == `PWMG_ENA) begin
			rsp.rdata[`PWMG_EN_BIT] = st.en;
		end else if (req.raddr == `PWMG_LOAD) begin
			rsp.rdata[15:0] = st.pend ? st.pend_load : st.load;
		end else if (req.raddr == `PWMG_CMPA) begin
			rsp.rdata[15:0] = st.pend ? st.pend_cmpa : st.cmpa;
		end else if (req.raddr == `PWMG_CMPB) begin
			rsp.rdata[15:0] = st.pend ? st.pend_cmpb : st.cmpb;
		end else if (req.raddr == `PWMG_DBCTL) begin
			rsp.rdata[0] = st.db_en;
		end else if (req.raddr == `PWMG_DBRISE) begin
			rsp.rdata[15:0] = st.db_rise;
		end else if (req.raddr == `PWMG_DBFALL) begin
			rsp.rdata[15:0] = st.db_fall;
		end else if (req.raddr == `PWMG_INTEN) begin
			rsp.rdata[5:0]  = st.int_en;
			rsp.rdata[13:8] = st.trg_en;
		end else if (req.raddr == `PWMG_RIS) begin
			rsp.rdata[5:0] = st.ris; // RL16
		end else if (req.raddr == `PWMG_MIS) begin
			rsp.rdata[5:0] = mis; // RL16
		end else if (req.raddr == `PWMG_ISC) begin
			rsp.rdata[`PWMG_FAULT_BIT] = st.fault;
		end else if (req.raddr == `PWMG_COUNT) begin
			rsp.rdata[15:0] = st.cnt;
		end
	end

	always_comb begin
		next_st = st;
		// register writes
		if (wr_at(req, `PWMG_CFG) && req.wstrb[0]) begin
			next_st.cfg = req.wdata[2:0];
			next_st.en  = 1'b0; // RL3
		end
		if (wr_at(req, `PWMG_ENA) && req.wstrb[0]) begin
			next_st.en = req.wdata[`PWMG_EN_BIT]; // RL12 RL13
		end
		// several writes before an update overwrite the pending copy
		if (wr_at(req, `PWMG_LOAD)) begin
			next_st.pend_load = merge16(st.pend ? st.pend_load : st.load, req.wdata,
				req.wstrb);
		end
		if (wr_at(req, `PWMG_CMPA)) begin
			next_st.pend_cmpa = merge16(st.pend ? st.pend_cmpa : st.cmpa, req.wdata,
				req.wstrb);
		end
		if (wr_at(req, `PWMG_CMPB)) begin
			next_st.pend_cmpb = merge16(st.pend ? st.pend_cmpb : st.cmpb, req.wdata,
				req.wstrb);
		end
		if (!st.pend) begin
			if (!wr_at(req, `PWMG_LOAD)) next_st.pend_load = st.load;
			if (!wr_at(req, `PWMG_CMPA)) next_st.pend_cmpa = st.cmpa;
			if (!wr_at(req, `PWMG_CMPB)) next_st.pend_cmpb = st.cmpb;
		end
		if (wr_at(req, `PWMG_DBCTL) && req.wstrb[0]) begin
			next_st.db_en = req.wdata[0]; // RL1 RL2
		end
		if (wr_at(req, `PWMG_DBRISE)) begin
			next_st.db_rise = merge16(st.db_rise, req.wdata, req.wstrb);
		end
		if (wr_at(req, `PWMG_DBFALL)) begin
			next_st.db_fall = merge16(st.db_fall, req.wdata, req.wstrb);
		end
		if (wr_at(req, `PWMG_INTEN)) begin
			if (req.wstrb[0]) next_st.int_en = req.wdata[5:0]; // RL21
			if (req.wstrb[1]) next_st.trg_en = req.wdata[13:8]; // RL21
		end
		// parameter transfer at counter zero
		if (apply) begin
			next_st.load   = st.pend_load; // RL9
			next_st.cmpa   = st.pend_cmpa;
			next_st.cmpb   = st.pend_cmpb;
			next_st.pend   = 1'b0;
			next_st.synced = 1'b0;
		end
		if (wr_at(req, `PWMG_LOAD) || wr_at(req, `PWMG_CMPA) || wr_at(req, `PWMG_CMPB)) begin
			next_st.pend = 1'b1; // RL6
		end
		// a sync that lands while nothing can transfer is kept for the next zero
		if (sync_evt && !apply && st.cfg.sync_mode) begin
			next_st.synced = 1'b1; // RL7
		end
		// counter
		if (run) begin // RL19
			if (!st.cfg.updown) begin
				next_st.dir_up = 1'b0;
				next_st.cnt = (st.cnt == `PWMG_RST16) ? st.load : st.cnt - 16'h0001; // RL4
			end else if (st.dir_up) begin
				if (st.cnt >= st.load) begin
					next_st.dir_up = 1'b0; // RL5
					next_st.cnt = (st.cnt == `PWMG_RST16) ? `PWMG_RST16 : st.cnt - 16'h0001;
				end else begin
					next_st.cnt = st.cnt + 16'h0001;
				end
			end else if (st.cnt == `PWMG_RST16) begin
				next_st.dir_up = 1'b1; // RL5
				next_st.cnt = (st.load == `PWMG_RST16) ? `PWMG_RST16 : 16'h0001;
			end else begin
				next_st.cnt = st.cnt - 16'h0001;
			end
			// down mode: high from reload, low at match; up/down: high up, low down
			if (!st.cfg.updown) begin
				if (st.cnt == `PWMG_RST16) next_st.raw_a = 1'b1; // RL22
				if (st.cnt == `PWMG_RST16) next_st.raw_b = 1'b1;
				if (evt[`PWMG_EV_AD]) next_st.raw_a = 1'b0;
				if (evt[`PWMG_EV_BD]) next_st.raw_b = 1'b0;
			end else begin
				if (evt[`PWMG_EV_AU]) next_st.raw_a = 1'b1; // RL22
				if (evt[`PWMG_EV_AD]) next_st.raw_a = 1'b0;
				if (evt[`PWMG_EV_BU]) next_st.raw_b = 1'b1;
				if (evt[`PWMG_EV_BD]) next_st.raw_b = 1'b0;
			end
		end
		// status: a new event wins over a clear in the same cycle
		next_st.ris     = (st.ris & ~clr) | evt; // RL14 RL15
		next_st.trig    = |(evt & st.trg_en); // RL21
		next_st.int_req = |(next_st.ris & st.int_en); // RL21
		next_st.fault   = (st.fault && !(wr_at(req, `PWMG_ISC) && req.wstrb[0] // RL17
			&& req.wdata[`PWMG_FAULT_BIT])) || fault_in;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	cfg_disables_a: assert property (@(posedge aclk) disable iff (!aresetn) // RL3
		wr_at(req, `PWMG_CFG) && req.wstrb[0] && !wr_at(req, `PWMG_ENA) |=> !st.en)
		else $error("config write left counter enabled");
	off_holds_a: assert property (@(posedge aclk) disable iff (!aresetn) // RL12
		!st.en |=> $stable(st.cnt))
		else $error("disabled counter moved");
	down_reload_a: assert property (@(posedge aclk) disable iff (!aresetn) // RL4
		run && !st.cfg.updown && st.cnt == 16'h0000 |=> st.cnt == $past(st.load))
		else $error("down counter did not reload");
	updown_turn_a: assert property (@(posedge aclk) disable iff (!aresetn) // RL5
		run && st.cfg.updown && st.dir_up && st.cnt == st.load && st.load != 16'h0000
		|=> !st.dir_up && st.cnt == $past(st.load) - 16'h0001)
		else $error("up/down counter did not turn at load");
	zero_only_a: assert property (@(posedge aclk) disable iff (!aresetn) // RL9
		!$stable(st.load) |-> $past(st.cnt) == 16'h0000)
		else $error("period changed away from zero");
	sync_wait_a: assert property (@(posedge aclk) disable iff (!aresetn) // RL6
		st.cfg.sync_mode && !st.synced && !sync_evt && st.pend |=> $stable(st.load))
		else $error("period applied without sync event");
	nosync_apply_a: assert property (@(posedge aclk) disable iff (!aresetn) // RL8
		!st.cfg.sync_mode && st.pend && st.cnt == 16'h0000 && !req.wr
		|=> !st.pend && st.load == $past(st.pend_load))
		else $error("unsynchronised update missed zero");
	halt_pause_a: assert property (@(posedge aclk) disable iff (!aresetn) // RL10
		st.en && debug_halt && !st.cfg.run_in_halt_select && st.cnt == 16'h0000
		|=> st.cnt == 16'h0000)
		else $error("counter moved during halt");
	w1c_clear_a: assert property (@(posedge aclk) disable iff (!aresetn) // RL14
		clr[0] && !evt[0] |=> !st.ris[0])
		else $error("write one did not clear status");
	fault_clear_a: assert property (@(posedge aclk) disable iff (!aresetn) // RL17
		wr_at(req, `PWMG_ISC) && req.wstrb[0] && req.wdata[0] && !fault_in |=> !st.fault)
		else $error("fault flag not cleared");
	// with a non-zero period every cycle the counter runs moves the count, in either mode
	run_halt_a: assert property (@(posedge aclk) disable iff (!aresetn) // RL11
		st.en && debug_halt && st.cfg.run_in_halt_select && st.load != 16'h0000
		|=> st.cnt != $past(st.cnt))
		else $error("counter stopped in run on halt");
	en_advance_a: assert property (@(posedge aclk) disable iff (!aresetn) // RL13
		st.en && !debug_halt && st.load != 16'h0000 |=> st.cnt != $past(st.cnt))
		else $error("enabled counter did not advance");
	load_event_a: assert property (@(posedge aclk) disable iff (!aresetn) // RL15
		run && st.cnt == st.load |=> st.ris[1])
		else $error("load event not flagged");
	zero_event_a: assert property (@(posedge aclk) disable iff (!aresetn) // RL20
		run && st.cnt == 16'h0000 |=> st.ris[0])
		else $error("zero event not flagged");
	trig_event_a: assert property (@(posedge aclk) disable iff (!aresetn) // RL21
		trig_pulse |-> $past(run))
		else $error("trigger without a counter event");
	// covers for the main scenarios
	cv_updown_c: cover property (@(posedge aclk) disable iff (!aresetn)
		run && st.cfg.updown && st.dir_up ##1 !st.dir_up);
	cv_sync_c: cover property (@(posedge aclk) disable iff (!aresetn)
		st.cfg.sync_mode && apply);
	cv_halt_c: cover property (@(posedge aclk) disable iff (!aresetn)
		st.en && debug_halt && !run);
	cv_db_c: cover property (@(posedge aclk) disable iff (!aresetn)
		st.db_en && first_output ##1 !first_output);
	cv_w1c_c: cover property (@(posedge aclk) disable iff (!aresetn)
		|clr && |st.ris);
endmodule : pwmg_gen

/* pwmg_stage.sv */
`timescale 1ns/1ps
module pwmg_stage (
	// clock and gate drives
	input  wire logic aclk,
	input  wire logic shoot_arm,
	input  wire logic first_output,
	input  wire logic second_output,
	// both switches on would short the supply
	output int        shoot_cnt
);
	initial shoot_cnt = 0;
	always @(posedge aclk) begin
		if (shoot_arm && first_output && second_output) begin
			shoot_cnt <= shoot_cnt + 1;
		end
	end
endmodule : pwmg_stage

/* pwmg_tb_top.sv */
`timescale 1ns/1ps
`include "pwmg_defines.svh"
module pwm_generator_block_control_tb_top;
	logic        aclk;
	logic        aresetn;
	logic [7:0]  awaddr;
	logic        awvalid;
	logic        awready;
	logic [31:0] wdata;
	logic [3:0]  wstrb;
	logic        wvalid;
	logic        wready;
	logic [1:0]  bresp;
	logic        bvalid;
	logic        bready;
	logic [7:0]  araddr;
	logic        arvalid;
	logic        arready;
	logic [31:0] rdata;
	logic [1:0]  rresp;
	logic        rvalid;
	logic        rready;
	logic        debug_halt;
	logic        fault_in;
	logic        first_output;
	logic        second_output;
	logic        trig_pulse;
	logic        int_req;
	logic        shoot_arm;
	int          shoot_cnt;
	int          num_errors;
	int          tests_run;
	int          cyc;
	logic [31:0] rd;
	logic [1:0]  rs;
	logic [31:0] n;

	pwmg_gen dut_u (.*);
	pwmg_stage stage_u (.*);

	initial begin
		aclk = 0;
		forever #2.5 aclk = ~aclk;
	end

	// a hang counts as a mismatch
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			num_errors++;
			wrap_up();
		end
	end

	task automatic wrap_up;
		$display("errors %0d checks %0d", num_errors, tests_run);
		if (num_errors == 0 && tests_run > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : wrap_up

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			num_errors++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic aw_hs;
		logic w_hs;
		logic b_hs;
		@(posedge aclk);
		awaddr  <= a;
		wdata   <= d;
		awvalid <= 1;
		wvalid  <= 1;
		bready  <= 1;
		do begin
			// handshakes judged mid-cycle, where ready has settled
			@(negedge aclk);
			aw_hs = awvalid && awready;
			w_hs  = wvalid && wready;
			b_hs  = bvalid && bready;
			@(posedge aclk);
			if (aw_hs) awvalid <= 0;
			if (w_hs) wvalid <= 0;
		end while (!b_hs);
		bready <= 0;
	endtask : wr

	task automatic rdr(input logic [7:0] a);
		logic ar_hs;
		logic r_hs;
		@(posedge aclk);
		araddr  <= a;
		arvalid <= 1;
		rready  <= 1;
		do begin
			@(negedge aclk);
			ar_hs = arvalid && arready;
			r_hs  = rvalid && rready;
			if (r_hs) begin
				rd = rdata;
				rs = rresp;
			end
			@(posedge aclk);
			if (ar_hs) arvalid <= 0;
		end while (!r_hs);
		rready <= 0;
	endtask : rdr

	task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string nm);
		rdr(a);
		chk(nm, e, rd);
	endtask : rchk

	// cycles between two rising edges of the first output
	task automatic per(output logic [31:0] c);
		logic p;
		@(negedge aclk);
		do begin
			p = first_output;
			@(negedge aclk);
		end while (!(first_output && !p));
		c = 0;
		do begin
			p = first_output;
			@(negedge aclk);
			c++;
		end while (!(first_output && !p));
	endtask : per

	// cycles for which the first output stays high
	task automatic hw(output logic [31:0] c);
		@(negedge aclk);
		while (first_output) @(negedge aclk);
		while (!first_output) @(negedge aclk);
		c = 0;
		while (first_output) begin
			@(negedge aclk);
			c++;
		end
	endtask : hw

	task automatic t_idle;
		wr(`PWMG_LOAD, 32'h3);
		wr(`PWMG_CMPA, 32'h1);
		wr(`PWMG_CMPB, 32'h2);
		repeat (5) @(posedge aclk);
		rchk(`PWMG_COUNT, 32'h0, "count");
		rchk(`PWMG_LOAD, 32'h3, "load");
	endtask : t_idle

	task automatic t_modes;
		wr(`PWMG_ENA, 32'h1);
		per(n);
		chk("down", 32'h4, n);
		wr(`PWMG_CFG, 32'h1);
		rchk(`PWMG_ENA, 32'h0, "ena");
		wr(`PWMG_ENA, 32'h1);
		per(n);
		chk("updown", 32'h6, n);
		wr(`PWMG_CFG, 32'h5);
		wr(`PWMG_ENA, 32'h1);
		debug_halt <= 1;
		per(n);
		chk("halt_run", 32'h6, n);
		@(posedge aclk);
		debug_halt <= 0;
	endtask : t_modes

	task automatic t_sync;
		wr(`PWMG_CFG, 32'h2);
		wr(`PWMG_ENA, 32'h1);
		wr(`PWMG_LOAD, 32'h5);
		per(n);
		per(n);
		chk("held", 32'h4, n);
		wr(`PWMG_SYNC, 32'h1);
		per(n);
		per(n);
		chk("synced", 32'h6, n);
		wr(`PWMG_CFG, 32'h0);
		wr(`PWMG_LOAD, 32'h3);
		wr(`PWMG_ENA, 32'h1);
		per(n);
		per(n);
		chk("direct", 32'h4, n);
	endtask : t_sync

	task automatic t_events;
		wr(`PWMG_INTEN, 32'h102);
		wr(`PWMG_RIS, 32'h3f);
		repeat (8) @(posedge aclk);
		debug_halt <= 1;
		repeat (8) @(posedge aclk);
		rchk(`PWMG_COUNT, 32'h0, "paused");
		rchk(`PWMG_RIS, 32'h2b, "raw");
		wr(`PWMG_RIS, 32'h8);
		rchk(`PWMG_RIS, 32'h23, "raw_clr");
		rchk(`PWMG_MIS, 32'h2, "masked");
		chk("int_req", 32'h1, int_req);
		debug_halt <= 0;
		// one zero event per four-cycle period
		n = 0;
		repeat (8) begin
			@(negedge aclk);
			n += trig_pulse;
		end
		chk("trig", 32'h2, n);
	endtask : t_events

	task automatic t_fault;
		fault_in <= 1;
		@(posedge aclk);
		fault_in <= 0;
		rchk(`PWMG_ISC, 32'h1, "fault");
		wr(`PWMG_ISC, 32'h1);
		rchk(`PWMG_ISC, 32'h0, "fault_clr");
		rdr(8'h40);
		chk("bad_resp", `PWMG_SLVERR, rs);
		chk("bad_data", 32'h0, rd);
	endtask : t_fault

	// second output from its own comparator would be high at this rise
	task automatic t_db;
		wr(`PWMG_CFG, 32'h0);
		wr(`PWMG_LOAD, 32'h9);
		wr(`PWMG_CMPA, 32'h4);
		wr(`PWMG_DBRISE, 32'h2);
		wr(`PWMG_DBFALL, 32'h2);
		wr(`PWMG_DBCTL, 32'h1);
		wr(`PWMG_ENA, 32'h1);
		per(n);
		shoot_arm <= 1;
		per(n);
		chk("db_period", 32'ha, n);
		chk("compl", 32'h0, second_output);
		hw(n);
		chk("db_high", 32'h4, n);
		per(n);
		chk("overlap", 32'h0, shoot_cnt);
	endtask : t_db

	initial begin
		num_errors = 0;
		tests_run  = 0;
		cyc        = 0;
		aresetn    = 0;
		awaddr     = 0;
		awvalid    = 0;
		wdata      = 0;
		wstrb      = 4'hf;
		wvalid     = 0;
		bready     = 0;
		araddr     = 0;
		arvalid    = 0;
		rready     = 0;
		debug_halt = 0;
		fault_in   = 0;
		shoot_arm  = 0;
		repeat (4) @(posedge aclk);
		aresetn <= 1;
		@(posedge aclk);
		t_idle();
		t_modes();
		t_sync();
		t_events();
		t_fault();
		t_db();
		wrap_up();
	end
endmodule : pwm_generator_block_control_tb_top
